// ===== hw/cogr_regs.sv
// Colour offset and gain register bank with an AXI4-Lite slave and the colour selector.
// Operation
// - Red offset code, eight bits, resets to 0x80, applied when red is selected.
// - Green offset code, eight bits, resets to 0x80, applied when green is selected.
// - Blue offset code, eight bits, resets to 0x80, applied when blue is selected.
// - Writing the broadcast offset location loads all three offset codes at once.
// - Red gain code resets to zero, sets red gain, applied when red is selected.
// - Green gain code resets to zero, same gain law, applied when green is selected.
// - Blue gain code resets to zero, same gain law, applied when blue is selected.
// - Writing the broadcast gain location loads all three gain codes at once.
// - Colour select: 00 red, 01 green, 10 blue, 11 reserved.
// - Any write to the software reset location restores every register default.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module cogr_regs
  import cogr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [DATA_W-1:0] s_axi_wdata_i,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [CODE_W-1:0] offset_code_o,
  output logic [CODE_W-1:0] gain_code_o,
  output logic [SEL_W-1:0] colour_select_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cogr_chan_if chan ();
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic wr_lane0;
  logic wr_go;
  logic wr_soft_reset;
  logic wr_mapped;
  logic [DATA_W-1:0] rd_value;
  logic rd_mapped;
  logic [SEL_W-1:0] colour_select;

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  // Address and data are held separately so the master may present them in either order.
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign wr_go = aw_held && w_held && !s_axi_bvalid_o;
  assign wr_soft_reset = wr_go && wr_addr == ADDR_SOFT_RESET;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_held <= 1'b0;
      wr_addr <= ADDR_OFFSET_RED;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held <= 1'b1;
      wr_addr <= s_axi_awaddr_i;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      w_held <= 1'b0;
      wr_data <= DATA_ZERO;
      wr_lane0 <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held <= 1'b1;
      wr_data <= s_axi_wdata_i;
      wr_lane0 <= s_axi_wstrb_i[0];
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    case (wr_addr)
      ADDR_OFFSET_RED, ADDR_OFFSET_GREEN, ADDR_OFFSET_BLUE, ADDR_OFFSET_ALL: wr_mapped = 1'b1;
      ADDR_GAIN_RED, ADDR_GAIN_GREEN, ADDR_GAIN_BLUE, ADDR_GAIN_ALL: wr_mapped = 1'b1;
      ADDR_CONTROL, ADDR_SOFT_RESET: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Colour registers
  // ----------------------------------------------------------------
  // Only byte lane 0 carries a code, so a write without it leaves the code alone.
  for (genvar c = 0; c < COLOURS; c++) begin : g_colour
    localparam logic [ADDR_W-1:0] OFF_ADDR = ADDR_W'(ADDR_OFFSET_RED + c * STRIDE);
    localparam logic [ADDR_W-1:0] GAIN_ADDR = ADDR_W'(ADDR_GAIN_RED + c * STRIDE);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        chan.offset_code[c] <= OFFSET_RESET;
      end else if (wr_soft_reset) begin
        chan.offset_code[c] <= OFFSET_RESET;
      end else if (wr_go && wr_lane0 && (wr_addr == OFF_ADDR || wr_addr == ADDR_OFFSET_ALL)) begin
        chan.offset_code[c] <= wr_data[CODE_W-1:0];
      end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        chan.gain_code[c] <= GAIN_RESET;
      end else if (wr_soft_reset) begin
        chan.gain_code[c] <= GAIN_RESET;
      end else if (wr_go && wr_lane0 && (wr_addr == GAIN_ADDR || wr_addr == ADDR_GAIN_ALL)) begin
        chan.gain_code[c] <= wr_data[CODE_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      colour_select <= SEL_RESET;
    end else if (wr_soft_reset) begin
      colour_select <= SEL_RESET;
    end else if (wr_go && wr_lane0 && wr_addr == ADDR_CONTROL) begin
      colour_select <= wr_data[SEL_W-1:0];
    end
  end

  assign chan.colour_select = colour_select;
  assign colour_select_o = colour_select;

  // ----------------------------------------------------------------
  // Selector and outputs
  // ----------------------------------------------------------------
  cogr_colour_mux u_mux (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .chan(chan)
  );

  assign offset_code_o = chan.sel_offset;
  assign gain_code_o = chan.sel_gain;

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // The broadcast and reset locations are write only and read back as zero.
  always_comb begin
    rd_value = DATA_ZERO;
    rd_mapped = 1'b1;
    case (s_axi_araddr_i)
      ADDR_OFFSET_RED: rd_value[CODE_W-1:0] = chan.offset_code[0];
      ADDR_OFFSET_GREEN: rd_value[CODE_W-1:0] = chan.offset_code[1];
      ADDR_OFFSET_BLUE: rd_value[CODE_W-1:0] = chan.offset_code[2];
      ADDR_GAIN_RED: rd_value[CODE_W-1:0] = chan.gain_code[0];
      ADDR_GAIN_GREEN: rd_value[CODE_W-1:0] = chan.gain_code[1];
      ADDR_GAIN_BLUE: rd_value[CODE_W-1:0] = chan.gain_code[2];
      ADDR_CONTROL: rd_value[SEL_W-1:0] = colour_select;
      ADDR_OFFSET_ALL, ADDR_GAIN_ALL, ADDR_SOFT_RESET: rd_value = DATA_ZERO;
      ADDR_STATUS: begin
        rd_value[CODE_W-1:0] = chan.sel_offset;
        rd_value[STAT_GAIN_LSB +: CODE_W] = chan.sel_gain;
        rd_value[STAT_SEL_LSB +: SEL_W] = colour_select;
      end
      default: rd_mapped = 1'b0;
    endcase
  end

  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= DATA_ZERO;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_value;
      s_axi_rresp_o <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_red_offset_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go && wr_lane0 && !wr_soft_reset && wr_addr == ADDR_OFFSET_RED
      |=> chan.offset_code[0] == $past(wr_data[CODE_W-1:0]) ##2 offset_code_o == $past(wr_data[CODE_W-1:0], 3)
        || colour_select != SEL_RED)
    else $error("Red offset write not stored or not applied.");
  a_green_offset_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go && wr_lane0 && wr_addr == ADDR_OFFSET_GREEN
      |=> chan.offset_code[1] == $past(wr_data[CODE_W-1:0]) && $stable(chan.offset_code[0]))
    else $error("Green offset write not stored alone.");
  a_blue_offset_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go && wr_lane0 && wr_addr == ADDR_OFFSET_BLUE
      |=> chan.offset_code[2] == $past(wr_data[CODE_W-1:0]) && $stable(chan.offset_code[1]))
    else $error("Blue offset write not stored alone.");
  a_offset_broadcast: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go && wr_lane0 && wr_addr == ADDR_OFFSET_ALL
      |=> chan.offset_code[0] == $past(wr_data[CODE_W-1:0]) && chan.offset_code[1] == chan.offset_code[0]
        && chan.offset_code[2] == chan.offset_code[0])
    else $error("Broadcast offset did not reach all colours.");
  a_red_gain_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go && wr_lane0 && wr_addr == ADDR_GAIN_RED
      |=> chan.gain_code[0] == $past(wr_data[CODE_W-1:0]) && $stable(chan.gain_code[1]))
    else $error("Red gain write not stored alone.");
  a_green_gain_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go && wr_lane0 && wr_addr == ADDR_GAIN_GREEN
      |=> chan.gain_code[1] == $past(wr_data[CODE_W-1:0]) && $stable(chan.gain_code[2]))
    else $error("Green gain write not stored alone.");
  a_blue_gain_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go && wr_lane0 && wr_addr == ADDR_GAIN_BLUE
      |=> chan.gain_code[2] == $past(wr_data[CODE_W-1:0]) && $stable(chan.gain_code[0]))
    else $error("Blue gain write not stored alone.");
  a_gain_broadcast: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go && wr_lane0 && wr_addr == ADDR_GAIN_ALL
      |=> chan.gain_code[0] == $past(wr_data[CODE_W-1:0]) && chan.gain_code[1] == chan.gain_code[0]
        && chan.gain_code[2] == chan.gain_code[0])
    else $error("Broadcast gain did not reach all colours.");
  a_soft_reset_all: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_soft_reset |=> chan.offset_code[0] == OFFSET_RESET && chan.offset_code[2] == OFFSET_RESET
      && chan.gain_code[1] == GAIN_RESET && colour_select == SEL_RESET ##1 offset_code_o == OFFSET_RESET)
    else $error("Software reset left a register off its default.");
  a_write_answer: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go |=> s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o)
    else $error("Write response not raised one clock after the write.");

  // ----------------------------------------------------------------
  // Selection, strobe, software reset, unmapped write and read-back checks
  // ----------------------------------------------------------------
  a_select_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go && wr_lane0 && wr_addr == ADDR_CONTROL
      |=> colour_select == $past(wr_data[SEL_W-1:0]))
    else $error("Colour select write not stored.");
  a_reserved_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    &colour_select
      |=> $stable(offset_code_o) && $stable(gain_code_o))
    else $error("Reserved selection changed the outputs.");
  a_blank_lane_offset: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go && !wr_lane0 && !wr_soft_reset
      |=> $stable(chan.offset_code[0]) && $stable(chan.offset_code[1]) && $stable(chan.offset_code[2]))
    else $error("Write without byte lane 0 changed an offset code.");
  a_blank_lane_gain: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go && !wr_lane0 && !wr_soft_reset
      |=> $stable(chan.gain_code[0]) && $stable(chan.gain_code[1]) && $stable(chan.gain_code[2]) && $stable(colour_select))
    else $error("Write without byte lane 0 changed a gain code or the selection.");
  a_soft_reset_gain: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_soft_reset |=> chan.offset_code[1] == OFFSET_RESET && chan.gain_code[0] == GAIN_RESET
      && chan.gain_code[2] == GAIN_RESET ##1 gain_code_o == GAIN_RESET)
    else $error("Software reset left a gain code off its default.");
  a_unmapped_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_go && !wr_mapped
      |=> s_axi_bresp_o == RESP_SLVERR && $stable(chan.offset_code[0]) && $stable(chan.gain_code[0]))
    else $error("Unmapped write not refused or changed a code.");
  a_read_red_offset: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == ADDR_OFFSET_RED
      |=> s_axi_rvalid_o && s_axi_rdata_o[CODE_W-1:0] == $past(chan.offset_code[0]))
    else $error("Red offset read back wrong.");
  a_read_green_offset: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == ADDR_OFFSET_GREEN
      |=> s_axi_rvalid_o && s_axi_rdata_o[CODE_W-1:0] == $past(chan.offset_code[1]))
    else $error("Green offset read back wrong.");
  a_read_blue_gain: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == ADDR_GAIN_BLUE
      |=> s_axi_rvalid_o && s_axi_rdata_o[CODE_W-1:0] == $past(chan.gain_code[2]))
    else $error("Blue gain read back wrong.");
  a_read_status: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == ADDR_STATUS
      |=> s_axi_rdata_o[CODE_W-1:0] == $past(offset_code_o) && s_axi_rdata_o[STAT_GAIN_LSB +: CODE_W] == $past(gain_code_o))
    else $error("Status read does not show the applied pair.");
  a_read_control: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == ADDR_CONTROL
      |=> s_axi_rdata_o[SEL_W-1:0] == $past(colour_select))
    else $error("Colour select read back wrong.");
  a_read_broadcast_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_axi_arvalid_i && s_axi_arready_o && (s_axi_araddr_i == ADDR_OFFSET_ALL || s_axi_araddr_i == ADDR_GAIN_ALL)
      |=> s_axi_rdata_o == DATA_ZERO && s_axi_rresp_o == RESP_OKAY)
    else $error("Broadcast location did not read back as zero.");

endmodule

// ===== include/cogr_pkg.sv
// Package with the register map, reset values and encodings of the colour offset and gain bank.
package cogr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int CODE_W = 8;
  localparam int COLOURS = 3;
  localparam int SEL_W = 2;
  localparam int STRIDE = 4;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_RED = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_GREEN = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_BLUE = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_ALL = 6'h0c;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_RED = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_GREEN = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_BLUE = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_ALL = 6'h1c;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 6'h20;
  localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET = 6'h24;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h28;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int STAT_GAIN_LSB = 8;
  localparam int STAT_SEL_LSB = 16;
  localparam logic [CODE_W-1:0] OFFSET_RESET = 8'h80;
  localparam logic [CODE_W-1:0] GAIN_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Colour selection and bus responses
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_RED = 2'h0;
  localparam logic [SEL_W-1:0] SEL_GREEN = 2'h1;
  localparam logic [SEL_W-1:0] SEL_BLUE = 2'h2;
  localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== include/cogr_chan_if.sv
// Interface carrying the colour codes to the selector and the selected pair back.
`timescale 1ns/1ns
interface cogr_chan_if;
  import cogr_pkg::*;
  logic [CODE_W-1:0] offset_code [COLOURS];
  logic [CODE_W-1:0] gain_code [COLOURS];
  logic [SEL_W-1:0] colour_select;
  logic [CODE_W-1:0] sel_offset;
  logic [CODE_W-1:0] sel_gain;
  modport bank (output offset_code, output gain_code, output colour_select, input sel_offset, input sel_gain);
  modport mux (input offset_code, input gain_code, input colour_select, output sel_offset, output sel_gain);
endinterface

// ===== hw/cogr_colour_mux.sv
// Selector that registers the offset and gain codes of the chosen colour.
`timescale 1ns/1ns
module cogr_colour_mux
  import cogr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  cogr_chan_if.mux chan
);

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // The reserved selection keeps the last pair so the analogue side never sees a code of no colour.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chan.sel_offset <= OFFSET_RESET;
      chan.sel_gain <= GAIN_RESET;
    end else begin
      case (chan.colour_select)
        SEL_RED: begin
          chan.sel_offset <= chan.offset_code[0];
          chan.sel_gain <= chan.gain_code[0];
        end
        SEL_GREEN: begin
          chan.sel_offset <= chan.offset_code[1];
          chan.sel_gain <= chan.gain_code[1];
        end
        SEL_BLUE: begin
          chan.sel_offset <= chan.offset_code[2];
          chan.sel_gain <= chan.gain_code[2];
        end
        default: begin
          chan.sel_offset <= chan.sel_offset;
          chan.sel_gain <= chan.sel_gain;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_red_pair_applied: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    chan.colour_select == SEL_RED |=> chan.sel_offset == $past(chan.offset_code[0])
      && chan.sel_gain == $past(chan.gain_code[0]))
    else $error("Red pair not applied one clock after selection.");
  a_green_pair_applied: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    chan.colour_select == SEL_GREEN |=> chan.sel_offset == $past(chan.offset_code[1])
      && chan.sel_gain == $past(chan.gain_code[1]))
    else $error("Green pair not applied one clock after selection.");
  a_blue_pair_applied: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    chan.colour_select == SEL_BLUE |=> chan.sel_offset == $past(chan.offset_code[2])
      && chan.sel_gain == $past(chan.gain_code[2]))
    else $error("Blue pair not applied one clock after selection.");

endmodule

// ===== testbench/tb.sv
// Self-checking testbench for the colour offset and gain register bank.
`timescale 1ns/1ns
module tb
  import cogr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and the design
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W/8-1:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] rdata;
  logic [CODE_W-1:0] offset_code, gain_code;
  logic [SEL_W-1:0] colour_select;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [CODE_W-1:0] exp_off [COLOURS] = '{8'h11, 8'h22, 8'h33};
  logic [CODE_W-1:0] exp_gain [COLOURS] = '{8'h44, 8'h55, 8'h66};

  always #2 clk_sys = ~clk_sys;

  cogr_regs i_dut (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .offset_code_o(offset_code),
    .gain_code_o(gain_code), .colour_select_o(colour_select));

  // ----------------------------------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [DATA_W-1:0] expected, input logic [DATA_W-1:0] seen);
    comparisons++;
    if (seen !== expected) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, expected, seen);
    end
  endtask

  // Address and data are offered together and each is released as soon as it is taken.
  task automatic wchk(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] value, input logic [1:0] exp_resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= addr;
    awvalid <= 1'b1;
    wdata <= value;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    check($sformatf("write response at %h", addr), DATA_W'(exp_resp), DATA_W'(bresp));
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] expected, input logic [1:0] exp_resp);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    check($sformatf("read data at %h", addr), expected, rdata);
    check($sformatf("read response at %h", addr), DATA_W'(exp_resp), DATA_W'(rresp));
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // The offset and gain outputs lag the registers by one clock; the bus tasks end late enough for them to settle.
  task automatic outchk(input logic [CODE_W-1:0] off, input logic [CODE_W-1:0] gain, input logic [SEL_W-1:0] sel);
    check("offset output", DATA_W'(off), DATA_W'(offset_code));
    check("gain output", DATA_W'(gain), DATA_W'(gain_code));
    check("colour select output", DATA_W'(sel), DATA_W'(colour_select));
  endtask

  task automatic defaults_chk();
    for (int i = 0; i < COLOURS; i++) begin
      rchk(ADDR_OFFSET_RED + ADDR_W'(STRIDE * i), DATA_W'(OFFSET_RESET), RESP_OKAY);
      rchk(ADDR_GAIN_RED + ADDR_W'(STRIDE * i), DATA_W'(GAIN_RESET), RESP_OKAY);
    end
    rchk(ADDR_CONTROL, DATA_ZERO, RESP_OKAY);
    outchk(OFFSET_RESET, GAIN_RESET, SEL_RED);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Timeout
  // ----------------------------------------------------------------
  // About sixty transfers of under ten cycles each; the ceiling leaves wide margin.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("unexpected timeout: expected completion seen hang");
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    defaults_chk();
    $display("test reset values done");

    for (int i = 0; i < COLOURS; i++) begin
      wchk(ADDR_OFFSET_RED + ADDR_W'(STRIDE * i), DATA_W'(exp_off[i]), RESP_OKAY);
      wchk(ADDR_GAIN_RED + ADDR_W'(STRIDE * i), DATA_W'(exp_gain[i]), RESP_OKAY);
    end
    for (int i = 0; i < COLOURS; i++) begin
      rchk(ADDR_OFFSET_RED + ADDR_W'(STRIDE * i), DATA_W'(exp_off[i]), RESP_OKAY);
      rchk(ADDR_GAIN_RED + ADDR_W'(STRIDE * i), DATA_W'(exp_gain[i]), RESP_OKAY);
    end
    for (int i = 0; i < COLOURS; i++) begin
      wchk(ADDR_CONTROL, DATA_W'(i), RESP_OKAY);
      outchk(exp_off[i], exp_gain[i], SEL_W'(i));
    end
    // The reserved selection keeps the last pair on the outputs.
    wchk(ADDR_CONTROL, 32'h0000_0003, RESP_OKAY);
    outchk(exp_off[2], exp_gain[2], 2'h3);
    $display("test colour selection done");

    wchk(ADDR_CONTROL, 32'h0000_0001, RESP_OKAY);
    wchk(ADDR_OFFSET_ALL, 32'h0000_00a5, RESP_OKAY);
    for (int i = 0; i < COLOURS; i++) begin
      rchk(ADDR_OFFSET_RED + ADDR_W'(STRIDE * i), 32'h0000_00a5, RESP_OKAY);
      rchk(ADDR_GAIN_RED + ADDR_W'(STRIDE * i), DATA_W'(exp_gain[i]), RESP_OKAY);
    end
    outchk(8'ha5, exp_gain[1], SEL_GREEN);
    wchk(ADDR_GAIN_ALL, 32'h0000_005a, RESP_OKAY);
    for (int i = 0; i < COLOURS; i++) begin
      rchk(ADDR_GAIN_RED + ADDR_W'(STRIDE * i), 32'h0000_005a, RESP_OKAY);
    end
    outchk(8'ha5, 8'h5a, SEL_GREEN);
    rchk(ADDR_STATUS, 32'h0001_5aa5, RESP_OKAY);
    rchk(ADDR_OFFSET_ALL, DATA_ZERO, RESP_OKAY);
    rchk(ADDR_GAIN_ALL, DATA_ZERO, RESP_OKAY);
    $display("test broadcast writes done");

    // Writes without byte lane 0 store nothing, but the software reset still acts.
    wstrb <= 4'he;
    wchk(ADDR_OFFSET_RED, 32'h0000_0012, RESP_OKAY);
    wchk(ADDR_CONTROL, 32'h0000_0002, RESP_OKAY);
    rchk(ADDR_OFFSET_RED, 32'h0000_00a5, RESP_OKAY);
    rchk(ADDR_CONTROL, 32'h0000_0001, RESP_OKAY);
    wchk(ADDR_SOFT_RESET, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'hf;
    defaults_chk();
    $display("test software reset done");

    wchk(6'h2c, 32'h0000_0077, RESP_SLVERR);
    wchk(6'h01, 32'h0000_0077, RESP_SLVERR);
    rchk(6'h2c, DATA_ZERO, RESP_SLVERR);
    defaults_chk();
    $display("test unmapped access done");
    summarize();
  end
endmodule
